// ### src/dcd_map.svh
/*
 * Constants for the DDR3 command and address decoder: command codes,
 * address bit positions, mode register indices and field reset values.
 * Assumes inclusion by its bare name from the package and the design.
 */
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH

`define DCD_NUM_BANKS      8
`define DCD_BANK_W         3
`define DCD_ADDR_W         15
`define DCD_COL_W          11
`define DCD_MODE_W         15

// Command codes on {cs_n, ras_n, cas_n, we_n}.
`define DCD_CMD_MRS        4'h0
`define DCD_CMD_REF        4'h1
`define DCD_CMD_PRE        4'h2
`define DCD_CMD_ACT        4'h3
`define DCD_CMD_WR         4'h4
`define DCD_CMD_RD         4'h5
`define DCD_CMD_ZQ         4'h6
`define DCD_CMD_NOP        4'h7

// Address bit positions, and the chip select bit within the command code.
`define DCD_AP_BIT         10
`define DCD_BC_BIT         12
`define DCD_COL_HI_BIT     11
`define DCD_CS_BIT         3

// Mode register indices on the bank address during a mode register set.
`define DCD_MR0            3'h0
`define DCD_MR1            3'h1
`define DCD_MR2            3'h2
`define DCD_MR3            3'h3

// Mode register 1 fields: termination strobe enable and nominal Rtt.
`define DCD_MR1_TDQS_BIT   11
`define DCD_MR1_RTT0_BIT   2
`define DCD_MR1_RTT1_BIT   6
`define DCD_MR1_RTT2_BIT   9
// Mode register 2 field: dynamic write Rtt.
`define DCD_MR2_RTTWR_LO   9
`define DCD_MR2_RTTWR_HI   10

`define DCD_MODE_RST       15'h0000
`define DCD_ROW_RST        15'h0000
`define DCD_COL_RST        11'h000
`define DCD_BANK_RST       3'h0

// Data width and column bits of the two organisations.
`define DCD_ORG_X4         4
`define DCD_ORG_X8         8
`define DCD_COLBITS_X4     11
`define DCD_COLBITS_X8     10

`endif

// ### src/dcd_pkg.sv
/*
 * Types for the DDR3 command and address decoder.
 * Assumes dcd_map.svh is on the include path.
 */
`include "dcd_map.svh"

package dcd_pkg;

  typedef enum logic [3:0] {
    DCD_ORGX4_T_UNUSED = 4'h0
  } dcd_unused_t;

  typedef enum logic [6:0] {
    DCD_OP_NONE = 7'h01,
    DCD_OP_ACT  = 7'h02,
    DCD_OP_RD   = 7'h04,
    DCD_OP_WR   = 7'h08,
    DCD_OP_PRE  = 7'h10,
    DCD_OP_MRS  = 7'h20,
    DCD_OP_OTH  = 7'h40
  } dcd_op_t;

  typedef logic [`DCD_ADDR_W-1:0] dcd_row_t;
  typedef logic [`DCD_COL_W-1:0]  dcd_col_t;
  typedef logic [`DCD_BANK_W-1:0] dcd_bank_t;

endpackage

// ### src/dcd_cmd_dec.sv
/*
 * Combinational command decoder: turns the chip select, row strobe,
 * column strobe and write enable inputs into one one-hot operation.
 * Assumes inputs already sampled on the rising clock edge.
 */
`timescale 1ns/100ps

module dcd_cmd_dec
  import dcd_pkg::*;
(
  input  wire logic    cs_n,
  input  wire logic    ras_n,
  input  wire logic    cas_n,
  input  wire logic    we_n,
  output dcd_op_t      op
);

  logic [3:0] code;

  assign code = {cs_n, ras_n, cas_n, we_n};

  always_comb begin
    op = DCD_OP_OTH;
    if (code[`DCD_CS_BIT]) begin
      op = DCD_OP_NONE;
    end else begin
      unique case (code)
        `DCD_CMD_ACT: op = DCD_OP_ACT;
        `DCD_CMD_RD:  op = DCD_OP_RD;
        `DCD_CMD_WR:  op = DCD_OP_WR;
        `DCD_CMD_PRE: op = DCD_OP_PRE;
        `DCD_CMD_MRS: op = DCD_OP_MRS;
        `DCD_CMD_NOP: op = DCD_OP_NONE;
        default:      op = DCD_OP_OTH;
      endcase
    end
  end

endmodule

// ### src/dcd_top.sv
/*
 * DDR3 command and address decoder as seen behind the device pins.
 * Holds per-bank open rows, the last access, the four mode registers
 * and the termination and mask pin function. Assumes the controller
 * drives all inputs synchronous to clk; reset_n is the device reset.
 */
`timescale 1ns/100ps

// What this block does
// - The bank address picks which of 8 banks a bank command acts on.
// - During a mode register set the bank address picks the register.
// - Read or write with address bit 10 high auto-precharges the bank.
// - Precharge with bit 10 low closes the addressed bank, high all banks.
// - Activate takes a 15-bit row; a column is bits 0-9, plus 11 on x4.
// - During a mode register set the address supplies the op-code.
// - Read or write with address bit 12 low chops the burst to four.
// - Termination high terminates data, strobe, mask and enabled x8 strobes.
// - Termination input is ignored while mode registers 1 and 2 disable it.
// - Reset is asynchronous and active low and holds reset while low.
// - Each activate opens a 1KB page: 2^column bits times width over 8.
// - Chip select high masks commands and is part of the command code.
// - On x8 mode register 1 bit 11 sets the shared pin to mask or strobe.
module dcd_top
  import dcd_pkg::*;
#(
  parameter bit IS_X8 = 1'b1
)
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    reset_n,
  input  wire logic                    cs_n,
  input  wire logic                    ras_n,
  input  wire logic                    cas_n,
  input  wire logic                    we_n,
  input  wire logic [`DCD_BANK_W-1:0]  bank_addr,
  input  wire logic [`DCD_ADDR_W-1:0]  addr,
  input  wire logic                    odt,
  output logic [`DCD_NUM_BANKS-1:0]    bank_open_ff,
  output logic [`DCD_NUM_BANKS*`DCD_ADDR_W-1:0] open_rows_ff,
  output logic                         acc_valid_ff,
  output logic                         acc_write_ff,
  output logic [`DCD_BANK_W-1:0]       acc_bank_ff,
  output logic [`DCD_ADDR_W-1:0]       acc_row_ff,
  output logic [`DCD_COL_W-1:0]        acc_col_ff,
  output logic                         acc_auto_pre_ff,
  output logic                         acc_chop_ff,
  output logic                         mrs_valid_ff,
  output logic [`DCD_BANK_W-1:0]       mrs_sel_ff,
  output logic [`DCD_MODE_W-1:0]       mode0_ff,
  output logic [`DCD_MODE_W-1:0]       mode1_ff,
  output logic [`DCD_MODE_W-1:0]       mode2_ff,
  output logic [`DCD_MODE_W-1:0]       mode3_ff,
  output logic                         term_on_ff,
  output logic                         term_strobe_on_ff,
  output logic                         mask_pin_is_tdqs_ff,
  output logic [15:0]                  page_bytes_ff
);

  //////////////////////////////////////////////////////////////////////////

  dcd_op_t                    op;
  logic [`DCD_NUM_BANKS-1:0]  bank_hit;
  dcd_row_t                   row_now;
  dcd_col_t                   col_now;
  logic                       rtt_nom_on;
  logic                       rtt_wr_on;
  logic                       nxt_term_on;
  logic [`DCD_NUM_BANKS-1:0]  nxt_bank_open;

  dcd_cmd_dec u_dec (
    .cs_n  (cs_n),
    .ras_n (ras_n),
    .cas_n (cas_n),
    .we_n  (we_n),
    .op    (op)
  );

  // One-hot bank selection, shared by activate, access and precharge.
  function automatic logic [`DCD_NUM_BANKS-1:0] bank_onehot(
    input logic [`DCD_BANK_W-1:0] ba
  );
    bank_onehot = '0;
    bank_onehot[ba] = 1'b1;
  endfunction

  assign bank_hit = bank_onehot(bank_addr);

  // Column bits: x8 leaves bit 11 out of the column.
  always_comb begin
    col_now = `DCD_COL_RST;
    col_now[9:0] = addr[9:0];
    if (!IS_X8) begin
      col_now[10] = addr[`DCD_COL_HI_BIT];
    end
  end

  // Row held open by the addressed bank, taken by read and write.
  always_comb begin
    row_now = `DCD_ROW_RST;
    for (int b = 0; b < `DCD_NUM_BANKS; b++) begin
      if (bank_hit[b]) begin
        row_now = open_rows_ff[b*`DCD_ADDR_W +: `DCD_ADDR_W];
      end
    end
  end

  // Read and write share every capture path.
  function automatic logic is_access(input dcd_op_t o);
    is_access = (o == DCD_OP_RD) || (o == DCD_OP_WR);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Bank state and open rows.

  always_comb begin
    nxt_bank_open = bank_open_ff;
    unique case (op)
      DCD_OP_ACT: nxt_bank_open = bank_open_ff | bank_hit;
      DCD_OP_PRE: begin
        if (addr[`DCD_AP_BIT]) begin
          nxt_bank_open = '0;
        end else begin
          nxt_bank_open = bank_open_ff & ~bank_hit;
        end
      end
      DCD_OP_RD, DCD_OP_WR: begin
        if (addr[`DCD_AP_BIT]) begin
          nxt_bank_open = bank_open_ff & ~bank_hit;
        end
      end
      DCD_OP_NONE, DCD_OP_MRS, DCD_OP_OTH: nxt_bank_open = bank_open_ff;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_open_ff <= '0;
    end else if (rst) begin
      bank_open_ff <= '0;
    end else begin
      bank_open_ff <= nxt_bank_open;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `DCD_NUM_BANKS; gi++) begin : g_row
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          open_rows_ff[gi*`DCD_ADDR_W +: `DCD_ADDR_W] <= `DCD_ROW_RST;
        end else if (rst) begin
          open_rows_ff[gi*`DCD_ADDR_W +: `DCD_ADDR_W] <= `DCD_ROW_RST;
        end else if (op == DCD_OP_ACT && bank_hit[gi]) begin
          open_rows_ff[gi*`DCD_ADDR_W +: `DCD_ADDR_W] <= addr;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Access capture for read and write.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_valid_ff    <= 1'b0;
      acc_write_ff    <= 1'b0;
      acc_bank_ff     <= `DCD_BANK_RST;
      acc_row_ff      <= `DCD_ROW_RST;
      acc_col_ff      <= `DCD_COL_RST;
      acc_auto_pre_ff <= 1'b0;
      acc_chop_ff     <= 1'b0;
    end else if (rst) begin
      acc_valid_ff    <= 1'b0;
      acc_write_ff    <= 1'b0;
      acc_bank_ff     <= `DCD_BANK_RST;
      acc_row_ff      <= `DCD_ROW_RST;
      acc_col_ff      <= `DCD_COL_RST;
      acc_auto_pre_ff <= 1'b0;
      acc_chop_ff     <= 1'b0;
    end else begin
      acc_valid_ff <= is_access(op);
      if (is_access(op)) begin
        acc_write_ff    <= (op == DCD_OP_WR);
        acc_bank_ff     <= bank_addr;
        acc_row_ff      <= row_now;
        acc_col_ff      <= col_now;
        acc_auto_pre_ff <= addr[`DCD_AP_BIT];
        acc_chop_ff     <= ~addr[`DCD_BC_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode registers.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mrs_valid_ff <= 1'b0;
      mrs_sel_ff   <= `DCD_BANK_RST;
      mode0_ff     <= `DCD_MODE_RST;
      mode1_ff     <= `DCD_MODE_RST;
      mode2_ff     <= `DCD_MODE_RST;
      mode3_ff     <= `DCD_MODE_RST;
    end else if (rst) begin
      mrs_valid_ff <= 1'b0;
      mrs_sel_ff   <= `DCD_BANK_RST;
      mode0_ff     <= `DCD_MODE_RST;
      mode1_ff     <= `DCD_MODE_RST;
      mode2_ff     <= `DCD_MODE_RST;
      mode3_ff     <= `DCD_MODE_RST;
    end else begin
      mrs_valid_ff <= (op == DCD_OP_MRS);
      if (op == DCD_OP_MRS) begin
        mrs_sel_ff <= bank_addr;
        if (bank_addr == `DCD_MR0) begin
          mode0_ff <= addr;
        end
        if (bank_addr == `DCD_MR1) begin
          mode1_ff <= addr;
        end
        if (bank_addr == `DCD_MR2) begin
          mode2_ff <= addr;
        end
        if (bank_addr == `DCD_MR3) begin
          mode3_ff <= addr;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Termination and shared mask pin function.

  assign rtt_nom_on = mode1_ff[`DCD_MR1_RTT0_BIT]
                    | mode1_ff[`DCD_MR1_RTT1_BIT]
                    | mode1_ff[`DCD_MR1_RTT2_BIT];
  assign rtt_wr_on  = mode2_ff[`DCD_MR2_RTTWR_LO]
                    | mode2_ff[`DCD_MR2_RTTWR_HI];
  assign nxt_term_on = odt & (rtt_nom_on | rtt_wr_on);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      term_on_ff          <= 1'b0;
      term_strobe_on_ff   <= 1'b0;
      mask_pin_is_tdqs_ff <= 1'b0;
    end else if (rst) begin
      term_on_ff          <= 1'b0;
      term_strobe_on_ff   <= 1'b0;
      mask_pin_is_tdqs_ff <= 1'b0;
    end else begin
      term_on_ff          <= nxt_term_on;
      term_strobe_on_ff   <= nxt_term_on & IS_X8
                           & mode1_ff[`DCD_MR1_TDQS_BIT];
      mask_pin_is_tdqs_ff <= IS_X8 & mode1_ff[`DCD_MR1_TDQS_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Page size in bytes, fixed by organisation.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_bytes_ff <= 16'h0000;
    end else if (rst) begin
      page_bytes_ff <= 16'h0000;
    end else if (IS_X8) begin
      page_bytes_ff <= 16'((32'h0000_0001 << `DCD_COLBITS_X8)
                           * `DCD_ORG_X8 / 8);
    end else begin
      page_bytes_ff <= 16'((32'h0000_0001 << `DCD_COLBITS_X4)
                           * `DCD_ORG_X4 / 8);
    end
  end

endmodule

// ### tb/dcd_ctl_model.sv
/*
 * Controller model that drives the command and address pins.
 * Assumes the bench calls cmd() and that clk is the device clock.
 */
`timescale 1ns/100ps

module dcd_ctl_model (
  input  wire logic        clk,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [2:0]       bank_addr,
  output logic [14:0]      addr
);
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    bank_addr = 3'h0;
    addr = 15'h0000;
  end

  // Deselect with inverted lines so a stale value never looks valid.
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                     input logic [14:0] a);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    bank_addr <= b;
    addr <= a;
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    bank_addr <= ~b;
    addr <= ~a;
  endtask
endmodule

// ### tb/dcd_top_checker.sv
/*
 * Concurrent checks on the ports of dcd_top.
 * Assumes commands are sampled on the rising edge of clk.
 */
`timescale 1ns/100ps
`include "dcd_map.svh"

module dcd_chk #(
  parameter bit IS_X8 = 1'b1
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          reset_n,
  input wire logic          cs_n,
  input wire logic          ras_n,
  input wire logic          cas_n,
  input wire logic          we_n,
  input wire logic [2:0]    bank_addr,
  input wire logic [14:0]   addr,
  input wire logic          odt,
  input wire logic [7:0]    bank_open_ff,
  input wire logic [119:0]  open_rows_ff,
  input wire logic          acc_valid_ff,
  input wire logic [10:0]   acc_col_ff,
  input wire logic          acc_auto_pre_ff,
  input wire logic          acc_chop_ff,
  input wire logic          mrs_valid_ff,
  input wire logic [14:0]   mode1_ff,
  input wire logic [14:0]   mode2_ff,
  input wire logic          term_on_ff,
  input wire logic          mask_pin_is_tdqs_ff,
  input wire logic [15:0]   page_bytes_ff
);
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire       rdwr = cmd == `DCD_CMD_RD || cmd == `DCD_CMD_WR;
  wire       en = |{mode1_ff[2], mode1_ff[6], mode1_ff[9], mode2_ff[10:9]};

  default clocking @(posedge clk); endclocking
  default disable iff (rst || !reset_n);

  sequence s_mr1;
    cmd == `DCD_CMD_MRS && bank_addr == `DCD_MR1;
  endsequence
  sequence s_loaded;
    mode1_ff == $past(addr) && mrs_valid_ff;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  chk_act_opens_bank: assert property (
    cmd == `DCD_CMD_ACT |=> bank_open_ff[$past(bank_addr)])
    else $error("activate left bank closed");
  chk_act_row_kept: assert property (
    cmd == `DCD_CMD_ACT |=>
    open_rows_ff[$past(bank_addr)*15 +: 15] == $past(addr))
    else $error("row not stored");
  chk_auto_pre_bit: assert property (
    rdwr |=> acc_valid_ff && acc_auto_pre_ff == $past(addr[10]))
    else $error("auto precharge wrong");
  chk_burst_chop: assert property (
    rdwr |=> acc_chop_ff == !$past(addr[12]))
    else $error("burst chop wrong");
  chk_col_capture: assert property (
    rdwr |=> acc_col_ff == {IS_X8 ? 1'b0 : $past(addr[11]),
                            $past(addr[9:0])})
    else $error("column wrong");
  chk_pre_all_banks: assert property (
    cmd == `DCD_CMD_PRE && addr[10] |=> bank_open_ff == 8'h00)
    else $error("precharge all left a bank open");
  chk_pre_one_bank: assert property (
    cmd == `DCD_CMD_PRE && !addr[10] |=> bank_open_ff ==
    ($past(bank_open_ff) & ~(8'h01 << $past(bank_addr))))
    else $error("single precharge wrong");
  chk_mrs_load: assert property (
    s_mr1 |=> s_loaded)
    else $error("mode register one not loaded");
  chk_cs_masks: assert property (
    cs_n |=> !acc_valid_ff && !mrs_valid_ff)
    else $error("deselected command taken");
  chk_term_follow: assert property (
    1'b1 |=> term_on_ff == $past(odt && en))
    else $error("termination wrong");
  chk_mask_select: assert property (
    1'b1 |=> mask_pin_is_tdqs_ff == (IS_X8 && $past(mode1_ff[11])))
    else $error("mask pin function wrong");
  chk_page_fixed: assert property (
    1'b1 |=> page_bytes_ff == 16'h0400)
    else $error("page size wrong");
endmodule

bind dcd_top dcd_chk #(.IS_X8(IS_X8)) u_dcd_chk (.*);

// ### tb/dcd_top_bench.sv
/*
 * Self-checking bench for dcd_top with a controller model.
 * Assumes a 200 MHz clock and one-cycle registered answers.
 */
`timescale 1ns/100ps
`include "dcd_map.svh"

module dcd_top_bench;
  import dcd_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         reset_n = 1'b1;
  logic         odt = 1'b0;
  logic         cs_n, ras_n, cas_n, we_n;
  logic [2:0]   bank_addr, acc_bank_ff, mrs_sel_ff;
  logic [14:0]  addr, acc_row_ff, mode0_ff, mode1_ff, mode2_ff, mode3_ff;
  logic [7:0]   bank_open_ff;
  logic [119:0] open_rows_ff;
  logic [10:0]  acc_col_ff;
  logic [15:0]  page_bytes_ff;
  logic         acc_valid_ff, acc_write_ff, acc_auto_pre_ff, acc_chop_ff;
  logic         mrs_valid_ff, term_on_ff, term_strobe_on_ff;
  logic         mask_pin_is_tdqs_ff;
  int           fail_count = 0;
  int           checks_done = 0;

  dcd_top u_dcd_top (.*);
  dcd_ctl_model u_dcd_ctl_model (.*);

  initial forever #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [119:0] seen, input logic [119:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic go(input logic [3:0] c, input logic [2:0] b,
                    input logic [14:0] a);
    u_dcd_ctl_model.cmd(c, b, a);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_banks();
    for (int b = 0; b < 8; b++) begin
      go(`DCD_CMD_ACT, 3'(b), 15'(15'h0911 * b + 15'h0105));
    end
    chk(bank_open_ff, 8'hff);
    for (int b = 0; b < 8; b++) begin
      chk(open_rows_ff[b*15 +: 15], 15'(15'h0911 * b + 15'h0105));
    end
    go(`DCD_CMD_RD, 3'h5, 15'h1aa5);
    chk({acc_valid_ff, acc_write_ff, acc_bank_ff, acc_row_ff},
        {2'h2, 3'h5, 15'h2e5a});
    chk({acc_col_ff, acc_auto_pre_ff, acc_chop_ff}, {11'h2a5, 2'h0});
    go(`DCD_CMD_WR, 3'h2, 15'h0433);
    chk({acc_write_ff, acc_row_ff, acc_col_ff},
        {1'b1, 15'h1327, 11'h033});
    chk({acc_auto_pre_ff, acc_chop_ff, bank_open_ff}, {2'h3, 8'hfb});
    go(4'hb, 3'h2, 15'h7fff);
    chk({acc_valid_ff, bank_open_ff}, {1'b0, 8'hfb});
    go(`DCD_CMD_REF, 3'h2, 15'h1400);
    chk({acc_valid_ff, mrs_valid_ff, bank_open_ff}, {2'h0, 8'hfb});
    go(`DCD_CMD_PRE, 3'h3, 15'h0000);
    chk(bank_open_ff, 8'hf3);
    go(`DCD_CMD_PRE, 3'h6, 15'h0400);
    chk(bank_open_ff, 8'h00);
  endtask

  task automatic t_mrs();
    for (int r = 0; r < 4; r++) begin
      go(`DCD_CMD_MRS, 3'(r), 15'(15'h1234 + r));
      chk({mrs_valid_ff, mrs_sel_ff}, {1'b1, 3'(r)});
    end
    go(`DCD_CMD_MRS, 3'h5, 15'h7777);
    chk(mrs_sel_ff, 3'h5);
    chk({mode3_ff, mode2_ff, mode1_ff, mode0_ff},
        {15'h1237, 15'h1236, 15'h1235, 15'h1234});
  endtask

  task automatic t_term();
    go(`DCD_CMD_MRS, `DCD_MR1, 15'h0804);
    @(posedge clk) odt <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({term_on_ff, term_strobe_on_ff}, 2'h3);
    chk(mask_pin_is_tdqs_ff, 1'b1);
    go(`DCD_CMD_MRS, `DCD_MR1, 15'h0000);
    go(`DCD_CMD_MRS, `DCD_MR2, 15'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk({term_on_ff, mask_pin_is_tdqs_ff}, 2'h0);
    @(posedge clk) odt <= 1'b0;
  endtask

  task automatic t_areset();
    go(`DCD_CMD_ACT, 3'h0, 15'h0abc);
    go(`DCD_CMD_MRS, `DCD_MR1, 15'h0004);
    @(posedge clk) reset_n <= 1'b0;
    #1;
    chk({bank_open_ff, mode1_ff, page_bytes_ff}, 39'h0);
    @(posedge clk) reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(page_bytes_ff, 16'h0400);
    go(`DCD_CMD_ACT, 3'h4, 15'h0123);
    chk(bank_open_ff, 8'h10);
  endtask

  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({page_bytes_ff, bank_open_ff}, {16'h0400, 8'h00});
    t_banks();
    t_mrs();
    t_term();
    t_areset();
    tally_and_finish();
  end
endmodule
